// [rtl/nfd_datapath.sv]
// Numeric format datapath: integer, decimal and float operations on words.
// Behaviour
// - Byte operands are unsigned 8-bit, legal from zero to 255.
// - Word operands are 16 independent bits, zero through FFFF.
// - Decimal operands hold four digits of zero to nine, total 9999.
// - Floats use the 32-bit single layout: sign, 8-bit exponent, 23 fraction.
// - A float's low half sits in the lower word, high half next.
// - Signed 16-bit values are two's complement, -32768 to +32767.
// - Signed 32-bit values span two words in two's complement.
// - Float result above the largest finite gives plus infinity, ok low.
// - Float result below the lowest finite gives minus infinity, ok low.
// - Adding plus and minus infinity returns NaN.
// - Float compare sets ok normally, clears it when an input is NaN.
`timescale 1ns/1ps
module nfd_datapath (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic start,
    input wire nfd_pkg::nfd_op_e op,
    input wire logic [15:0] opa_lo,
    input wire logic [15:0] opa_hi,
    input wire logic [15:0] opb_lo,
    input wire logic [15:0] opb_hi,
    output logic done,
    output logic ok,
    output logic [15:0] res_lo,
    output logic [15:0] res_hi
);
    nfd_pkg::nfd_state_s st_r;
    nfd_pkg::nfd_state_s st_nxt;

    logic [31:0] a_bits;
    logic [31:0] b_bits;
    logic a_sign;
    logic b_sign;
    logic [7:0] a_exp;
    logic [7:0] b_exp;
    logic [23:0] a_mant;
    logic [23:0] b_mant;
    logic a_nan;
    logic b_nan;
    logic a_inf;
    logic b_inf;

    // Each float operand is decoded by its own instance of the unpack unit.
    nfd_fp_unpack #(.HALF_W(nfd_pkg::WORD_W)) u_unpack_a (
        .word_lo(opa_lo),
        .word_hi(opa_hi),
        .bits(a_bits),
        .sign(a_sign),
        .exp_eff(a_exp),
        .mant(a_mant),
        .is_nan(a_nan),
        .is_inf(a_inf)
    );

    nfd_fp_unpack #(.HALF_W(nfd_pkg::WORD_W)) u_unpack_b (
        .word_lo(opb_lo),
        .word_hi(opb_hi),
        .bits(b_bits),
        .sign(b_sign),
        .exp_eff(b_exp),
        .mant(b_mant),
        .is_nan(b_nan),
        .is_inf(b_inf)
    );

    localparam logic [9:0] EXP_ONE_L = nfd_pkg::EXP_ONE;

    // Float adder: aligns, adds, normalises and rounds to nearest even.
    logic [31:0] fadd_res;
    logic fadd_ok;
    always_comb begin
        logic bs;
        logic xs;
        logic ys;
        logic [7:0] xe;
        logic [7:0] ye;
        logic [23:0] xm;
        logic [23:0] ym;
        logic [7:0] diff;
        logic [26:0] y_ext;
        logic [26:0] y_sh;
        logic stk;
        logic [27:0] sum;
        logic [26:0] n;
        logic [9:0] ex;
        logic [4:0] pos;
        logic [4:0] lz;
        logic rnd_up;
        logic [24:0] m25;
        logic [9:0] ef;
        bs = b_sign ^ (op == nfd_pkg::OP_FLOAT_SUB);
        xs = a_sign;
        ys = bs;
        xe = a_exp;
        ye = b_exp;
        xm = a_mant;
        ym = b_mant;
        diff = 8'h00;
        y_ext = 27'h000_0000;
        y_sh = 27'h000_0000;
        stk = 1'b0;
        sum = 28'h000_0000;
        n = 27'h000_0000;
        ex = 10'h000;
        pos = 5'h00;
        lz = 5'h00;
        rnd_up = 1'b0;
        m25 = 25'h000_0000;
        ef = 10'h000;
        fadd_res = 32'h0000_0000;
        fadd_ok = 1'b1;
        // The larger magnitude goes first so the difference stays positive.
        if ({b_exp, b_mant} > {a_exp, a_mant}) begin
            xs = bs;
            ys = a_sign;
            xe = b_exp;
            ye = a_exp;
            xm = b_mant;
            ym = a_mant;
        end
        diff = xe - ye;
        y_ext = {ym, 3'b000};
        // Bits shifted out are kept as one sticky bit for correct rounding.
        if (diff >= nfd_pkg::ALIGN_LIMIT) begin
            y_sh = 27'h000_0000;
            stk = |ym;
        end else begin
            y_sh = y_ext >> diff;
            stk = |(y_ext & ((27'h000_0001 << diff) - 27'h000_0001));
        end
        y_sh[0] = y_sh[0] | stk;
        if (xs == ys) begin
            sum = {1'b0, xm, 3'b000} + {1'b0, y_sh};
        end else begin
            sum = {1'b0, xm, 3'b000} - {1'b0, y_sh};
        end
        ex = {2'b00, xe};
        // Carry out shifts right once; otherwise shift left to the top bit.
        if (sum[27]) begin
            n = {sum[27:2], sum[1] | sum[0]};
            ex = ex + EXP_ONE_L;
        end else begin
            for (int i = 0; i < 27; i++) begin
                if (sum[i]) begin
                    pos = 5'(i);
                end
            end
            lz = nfd_pkg::NORM_TOP - pos;
            // A denormal result stops shifting at the smallest exponent.
            if ({5'h00, lz} > ex - EXP_ONE_L) begin
                lz = 5'(ex - EXP_ONE_L);
            end
            n = sum[26:0] << lz;
            ex = ex - {5'h00, lz};
        end
        rnd_up = n[2] & (n[1] | n[0] | n[3]);
        m25 = {1'b0, n[26:3]} + {24'h00_0000, rnd_up};
        if (m25[24]) begin
            ef = ex + EXP_ONE_L;
        end else if (m25[23]) begin
            ef = ex;
        end else begin
            ef = 10'h000;
        end
        fadd_res = {xs, ef[7:0], m25[22:0]};
        if (sum == 28'h000_0000) begin
            fadd_res = {(xs & ys), 31'h0000_0000};
        end
        // Overflow saturates to the infinity of the result's sign.
        if (ef >= nfd_pkg::EXP_OVERFLOW) begin
            fadd_ok = 1'b0;
            fadd_res = xs ? nfd_pkg::MINUS_INFINITY_CODE
                          : nfd_pkg::PLUS_INFINITY_CODE;
        end
        // Infinite operands pass through; opposite infinities give the quiet NaN with ok low.
        if (a_inf || b_inf) begin
            fadd_ok = 1'b1;
            fadd_res = a_inf ? a_bits : {bs, b_bits[30:0]};
            if (a_inf && b_inf && (a_sign != bs)) begin
                fadd_ok = 1'b0;
                fadd_res = nfd_pkg::QUIET_NAN_CODE;
            end
        end
        if (a_nan || b_nan) begin
            fadd_ok = 1'b0;
            fadd_res = nfd_pkg::QUIET_NAN_CODE;
        end
    end

    // Ordered keys make float compare a plain unsigned compare.
    logic [31:0] a_key;
    logic [31:0] b_key;
    logic [31:0] a_nz;
    logic [31:0] b_nz;
    assign a_nz = (a_bits[30:0] == 31'h0000_0000) ? 32'h0000_0000 : a_bits;
    assign b_nz = (b_bits[30:0] == 31'h0000_0000) ? 32'h0000_0000 : b_bits;
    assign a_key = a_nz[31] ? ~a_nz : (a_nz | nfd_pkg::SIGN_BIT);
    assign b_key = b_nz[31] ? ~b_nz : (b_nz | nfd_pkg::SIGN_BIT);

    // Integer sums with two's complement overflow detection.
    logic [15:0] int_sum;
    logic [31:0] signed32_type_sum;
    assign int_sum = opa_lo + opb_lo;
    assign signed32_type_sum = {opa_hi, opa_lo} + {opb_hi, opb_lo};

    // Next state: one request computed in each cycle that start is high.
    always_comb begin
        logic [13:0] bcd_bin;
        bcd_bin = 14'h0000;
        st_nxt = st_r;
        st_nxt.done = 1'b0;
        if (start) begin
            st_nxt.done = 1'b1;
            st_nxt.ok = 1'b1;
            st_nxt.res = 32'h0000_0000;
            case (op)
                nfd_pkg::OP_BYTE_CHECK: begin
                    st_nxt.ok = (opa_lo <= nfd_pkg::BYTE_MAX);
                    st_nxt.res = {24'h00_0000, opa_lo[7:0]};
                end
                nfd_pkg::OP_WORD_AND: begin
                    st_nxt.res = {16'h0000, opa_lo & opb_lo};
                end
                nfd_pkg::OP_BCD_TO_BIN: begin
                    st_nxt.ok = (opa_lo[15:12] <= nfd_pkg::BCD_DIGIT_MAX) &&
                                (opa_lo[11:8] <= nfd_pkg::BCD_DIGIT_MAX) &&
                                (opa_lo[7:4] <= nfd_pkg::BCD_DIGIT_MAX) &&
                                (opa_lo[3:0] <= nfd_pkg::BCD_DIGIT_MAX);
                    bcd_bin = 14'({10'h000, opa_lo[15:12]} *
                                  nfd_pkg::BCD_W_THOUSAND) +
                              14'({10'h000, opa_lo[11:8]} *
                                  nfd_pkg::BCD_W_HUNDRED) +
                              14'({10'h000, opa_lo[7:4]} *
                                  nfd_pkg::BCD_W_TEN) +
                              {10'h000, opa_lo[3:0]};
                    st_nxt.res = {18'h0_0000, bcd_bin};
                end
                nfd_pkg::OP_INT_ADD: begin
                    st_nxt.ok = !((opa_lo[15] == opb_lo[15]) &&
                                  (int_sum[15] != opa_lo[15]));
                    st_nxt.res = {{16{int_sum[15]}}, int_sum};
                end
                nfd_pkg::OP_SIGNED32_TYPE_ADD: begin
                    st_nxt.ok = !((opa_hi[15] == opb_hi[15]) &&
                                  (signed32_type_sum[31] != opa_hi[15]));
                    st_nxt.res = signed32_type_sum;
                end
                nfd_pkg::OP_FLOAT_ADD, nfd_pkg::OP_FLOAT_SUB: begin
                    st_nxt.ok = fadd_ok;
                    st_nxt.res = fadd_res;
                end
                nfd_pkg::OP_FLOAT_GT, nfd_pkg::OP_FLOAT_EQ,
                nfd_pkg::OP_FLOAT_LT: begin
                    st_nxt.ok = !(a_nan || b_nan);
                    if (!(a_nan || b_nan)) begin
                        if (op == nfd_pkg::OP_FLOAT_GT) begin
                            st_nxt.res[0] = (a_key > b_key);
                        end else if (op == nfd_pkg::OP_FLOAT_EQ) begin
                            st_nxt.res[0] = (a_key == b_key);
                        end else begin
                            st_nxt.res[0] = (a_key < b_key);
                        end
                    end
                end
                default: begin
                    st_nxt.ok = 1'b0;
                end
            endcase
        end
    end

    // State register.
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Outputs come straight from the state register.
    assign done = st_r.done;
    assign ok = st_r.ok;
    assign res_lo = st_r.res[15:0];
    assign res_hi = st_r.res[31:16];
endmodule

// [rtl/nfd_pkg.sv]
// Package with constants and types shared by the numeric format datapath.
package nfd_pkg;
    localparam int WORD_W = 16;
    localparam int DWORD_W = 32;
    localparam logic [15:0] BYTE_MAX = 16'h00FF;
    localparam logic [3:0] BCD_DIGIT_MAX = 4'h9;
    localparam logic [13:0] BCD_W_THOUSAND = 14'h03E8;
    localparam logic [13:0] BCD_W_HUNDRED = 14'h0064;
    localparam logic [13:0] BCD_W_TEN = 14'h000A;
    localparam logic [31:0] PLUS_INFINITY_CODE = 32'h7F80_0000;
    localparam logic [31:0] MINUS_INFINITY_CODE = 32'hFF80_0000;
    localparam logic [31:0] QUIET_NAN_CODE = 32'h7FC0_0000;
    localparam logic [31:0] SIGN_BIT = 32'h8000_0000;
    localparam logic [7:0] EXP_ALL_ONES = 8'hFF;
    localparam logic [9:0] EXP_OVERFLOW = 10'h0FF;
    localparam logic [9:0] EXP_ONE = 10'h001;
    localparam logic [7:0] ALIGN_LIMIT = 8'h1B;
    localparam logic [4:0] NORM_TOP = 5'h1A;

    // Operations the datapath can carry out on one request.
    typedef enum logic [3:0] {
        OP_BYTE_CHECK,
        OP_WORD_AND,
        OP_BCD_TO_BIN,
        OP_INT_ADD,
        OP_SIGNED32_TYPE_ADD,
        OP_FLOAT_ADD,
        OP_FLOAT_SUB,
        OP_FLOAT_GT,
        OP_FLOAT_EQ,
        OP_FLOAT_LT
    } nfd_op_e;

    // Complete registered state of the datapath.
    typedef struct packed {
        logic done;
        logic ok;
        logic [31:0] res;
    } nfd_state_s;
endpackage

// [rtl/nfd_fp_unpack.sv]
// Splits a float held in two memory words into its fields and classes.
`timescale 1ns/1ps
module nfd_fp_unpack #(
    parameter int HALF_W = 16
) (
    input wire logic [HALF_W-1:0] word_lo,
    input wire logic [HALF_W-1:0] word_hi,
    output logic [2*HALF_W-1:0] bits,
    output logic sign,
    output logic [7:0] exp_eff,
    output logic [23:0] mant,
    output logic is_nan,
    output logic is_inf
);
    // Low word is the less significant half, the next word the upper half.
    assign bits = {word_hi, word_lo};
    // Sign, 8-bit exponent and 23-bit fraction of the single layout.
    assign sign = bits[31];
    assign exp_eff = (bits[30:23] == 8'h00) ? 8'h01 : bits[30:23];
    assign mant = {(bits[30:23] != 8'h00), bits[22:0]};
    assign is_nan = (bits[30:23] == nfd_pkg::EXP_ALL_ONES) &&
                    (bits[22:0] != 23'h00_0000);
    assign is_inf = (bits[30:23] == nfd_pkg::EXP_ALL_ONES) &&
                    (bits[22:0] == 23'h00_0000);
endmodule

// [verif/nfd_datapath_props.sv]
// Assertions and covers watching the numeric format datapath ports.
`timescale 1ns/1ps
module nfd_datapath_props (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic start,
    input wire nfd_pkg::nfd_op_e op,
    input wire logic [15:0] opa_lo,
    input wire logic [15:0] opa_hi,
    input wire logic [15:0] opb_lo,
    input wire logic [15:0] opb_hi,
    input wire logic done,
    input wire logic ok,
    input wire logic [15:0] res_lo,
    input wire logic [15:0] res_hi
);
    logic a_fin;
    logic b_fin;
    logic a_nan;
    logic is_cmp;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);
    // Operand classes used by the float properties below.
    assign a_fin = opa_hi[14:7] != 8'hFF;
    assign b_fin = opb_hi[14:7] != 8'hFF;
    assign a_nan = !a_fin && (opa_hi[6:0] != 7'h00 || opa_lo != 16'h0000);
    assign is_cmp = op inside {nfd_pkg::OP_FLOAT_GT, nfd_pkg::OP_FLOAT_EQ,
        nfd_pkg::OP_FLOAT_LT};
    a_done_after: assert property (start |=> done)
        else $error("done missing one cycle after start");
    a_result_hold: assert property (!done |-> $stable(res_lo) &&
        $stable(res_hi) && $stable(ok))
        else $error("result moved without done");
    a_byte_range: assert property (
        start && op == nfd_pkg::OP_BYTE_CHECK |=>
        ok == ($past(opa_lo) <= nfd_pkg::BYTE_MAX))
        else $error("byte range flag wrong");
    a_word_and: assert property (
        start && op == nfd_pkg::OP_WORD_AND |=>
        ok && res_lo == ($past(opa_lo) & $past(opb_lo)))
        else $error("word and result wrong");
    a_int_sum: assert property (
        start && op == nfd_pkg::OP_INT_ADD |=>
        res_lo == 16'($past(opa_lo) + $past(opb_lo)) &&
        res_hi == {16{res_lo[15]}})
        else $error("signed 16-bit sum wrong");
    a_signed32_type_sum: assert property (
        start && op == nfd_pkg::OP_SIGNED32_TYPE_ADD |=> {res_hi, res_lo} ==
        32'({$past(opa_hi), $past(opa_lo)} + {$past(opb_hi), $past(opb_lo)}))
        else $error("signed 32-bit sum wrong");
    a_ovf_to_inf: assert property (
        start && op inside {nfd_pkg::OP_FLOAT_ADD, nfd_pkg::OP_FLOAT_SUB} &&
        a_fin && b_fin |=>
        res_hi[14:7] != 8'hFF ||
        (!ok && res_hi[6:0] == 7'h00 && res_lo == 16'h0000))
        else $error("overflow not saturated with ok low");
    a_inf_sum_nan: assert property (
        start && op == nfd_pkg::OP_FLOAT_ADD &&
        {opa_hi, opa_lo} == nfd_pkg::PLUS_INFINITY_CODE &&
        {opb_hi, opb_lo} == nfd_pkg::MINUS_INFINITY_CODE |=>
        res_hi[14:7] == 8'hFF && (res_hi[6:0] != 7'h00 || res_lo != 16'h0000))
        else $error("opposite infinities did not give NaN");
    a_cmp_nan: assert property (start && is_cmp && a_nan |=>
        !ok && res_lo == 16'h0000)
        else $error("compare with NaN kept ok");
    c_float_add: cover property (start && op == nfd_pkg::OP_FLOAT_ADD);
    c_compare: cover property (start && is_cmp ##1 ok);
    c_fail_out: cover property (done && !ok);
endmodule
bind nfd_datapath nfd_datapath_props props_u (.mclk, .resetn, .start, .op,
    .opa_lo, .opa_hi, .opb_lo, .opb_hi, .done, .ok, .res_lo, .res_hi);

// [verif/nfd_word_mem.sv]
// Word memory model that feeds operands and stores results.
`timescale 1ns/1ps
module nfd_word_mem (
    input wire logic mclk,
    input wire logic done,
    input wire logic [15:0] res_lo,
    input wire logic [15:0] res_hi,
    output logic [15:0] opa_lo,
    output logic [15:0] opa_hi,
    output logic [15:0] opb_lo,
    output logic [15:0] opb_hi
);
    logic [15:0] mem [0:5] = '{default: 16'h0000};
    // Less significant half sits at the lower address.
    assign opa_lo = mem[0];
    assign opa_hi = mem[1];
    assign opb_lo = mem[2];
    assign opb_hi = mem[3];
    // Each finished result lands in words four and five.
    always @(posedge mclk) begin
        if (done) begin
            mem[4] <= res_lo;
            mem[5] <= res_hi;
        end
    end
    task automatic put(input int adr, input logic [31:0] v);
        mem[adr] = v[15:0];
        mem[adr+1] = v[31:16];
    endtask
endmodule

// [verif/test_nfd_datapath.sv]
// Self-checking testbench for the numeric format datapath.
`timescale 1ns/1ps
module test_nfd_datapath;
    logic mclk = 1'b0;
    logic resetn = 1'b0;
    logic start = 1'b0;
    nfd_pkg::nfd_op_e op = nfd_pkg::OP_BYTE_CHECK;
    logic [15:0] opa_lo, opa_hi, opb_lo, opb_hi, res_lo, res_hi;
    logic done, ok;
    int failures = 0;
    int checked = 0;
    // Clock at 4 ns period.
    always #2 mclk = ~mclk;
    nfd_datapath dut_u (.mclk, .resetn, .start, .op, .opa_lo, .opa_hi,
        .opb_lo, .opb_hi, .done, .ok, .res_lo, .res_hi);
    nfd_word_mem mem_u (.mclk, .done, .res_lo, .res_hi, .opa_lo, .opa_hi,
        .opb_lo, .opb_hi);
    task automatic chk(input string what, input logic [31:0] seen,
        input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic close_out;
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // One request from memory; checks flags and the stored result words.
    task automatic run(input nfd_pkg::nfd_op_e o, input logic [31:0] a,
        input logic [31:0] b, input logic eok, input logic [31:0] eres);
        mem_u.put(0, a);
        mem_u.put(2, b);
        op = o;
        start = 1'b1;
        @(negedge mclk);
        start = 1'b0;
        chk("done", {31'h0, done}, 32'h1);
        chk("ok", {31'h0, ok}, {31'h0, eok});
        @(negedge mclk);
        chk("done_drop", {31'h0, done}, 32'h0);
        chk("stored", {mem_u.mem[5], mem_u.mem[4]}, eres);
    endtask
    task automatic t_int_formats;
        run(nfd_pkg::OP_BYTE_CHECK, 32'h0000_00FF, 0, 1, 32'h0000_00FF);
        run(nfd_pkg::OP_BYTE_CHECK, 32'h0000_0100, 0, 0, 32'h0000_0000);
        run(nfd_pkg::OP_WORD_AND, 32'h0000_FFFF, 32'h0000_A5C3, 1,
            32'h0000_A5C3);
        run(nfd_pkg::OP_BCD_TO_BIN, 32'h0000_9999, 0, 1, 32'h0000_270F);
        run(nfd_pkg::OP_BCD_TO_BIN, 32'h0000_12A4, 0, 0, 32'h0000_0518);
        run(nfd_pkg::OP_INT_ADD, 32'h0000_7FFF, 32'h0000_0001, 0,
            32'hFFFF_8000);
        run(nfd_pkg::OP_INT_ADD, 32'h0000_FFFF, 32'h0000_8001, 1,
            32'hFFFF_8000);
        run(nfd_pkg::OP_SIGNED32_TYPE_ADD, 32'h7FFF_FFFF, 32'h8000_0001, 1, 0);
        run(nfd_pkg::OP_SIGNED32_TYPE_ADD, 32'h8000_0000, 32'hFFFF_FFFF, 0,
            32'h7FFF_FFFF);
    endtask
    task automatic t_float;
        run(nfd_pkg::OP_FLOAT_ADD, 32'h3F80_0000, 32'h4000_0000, 1,
            32'h4040_0000);
        run(nfd_pkg::OP_FLOAT_SUB, 32'h4040_0000, 32'h3F80_0000, 1,
            32'h4000_0000);
        // Half-unit ties round to the even neighbour.
        run(nfd_pkg::OP_FLOAT_ADD, 32'h3F80_0001, 32'h3380_0000, 1,
            32'h3F80_0002);
        run(nfd_pkg::OP_FLOAT_ADD, 32'h3F80_0000, 32'h3380_0000, 1,
            32'h3F80_0000);
        run(nfd_pkg::OP_FLOAT_ADD, 32'h7F7F_FFFF, 32'h7F7F_FFFF, 0,
            nfd_pkg::PLUS_INFINITY_CODE);
        run(nfd_pkg::OP_FLOAT_ADD, 32'hFF7F_FFFF, 32'hFF7F_FFFF, 0,
            nfd_pkg::MINUS_INFINITY_CODE);
        run(nfd_pkg::OP_FLOAT_ADD, nfd_pkg::PLUS_INFINITY_CODE,
            nfd_pkg::MINUS_INFINITY_CODE, 0, nfd_pkg::QUIET_NAN_CODE);
        run(nfd_pkg::OP_FLOAT_GT, 32'h4000_0000, 32'h3F80_0000, 1, 1);
        run(nfd_pkg::OP_FLOAT_EQ, 32'h0000_0000, 32'h8000_0000, 1, 1);
        run(nfd_pkg::OP_FLOAT_LT, 32'h7FC0_0000, 32'h3F80_0000, 0, 0);
    endtask
    // Two requests on consecutive edges each give their own result.
    task automatic t_back;
        mem_u.put(0, 32'h0000_00F0);
        mem_u.put(2, 32'h0000_0FF0);
        op = nfd_pkg::OP_WORD_AND;
        start = 1'b1;
        @(negedge mclk);
        chk("first", {16'h0, res_lo}, 32'h0000_00F0);
        mem_u.put(0, 32'h0000_0F0F);
        @(negedge mclk);
        start = 1'b0;
        chk("second", {16'h0, res_lo}, 32'h0000_0F00);
        chk("done_twice", {31'h0, done}, 32'h1);
        @(negedge mclk);
    endtask
    // Main sequence after a 12-cycle reset.
    initial begin
        repeat (12) @(negedge mclk);
        resetn = 1'b1;
        @(negedge mclk);
        t_int_formats();
        t_float();
        t_back();
        close_out();
    end
    // Watchdog well beyond the expected run length.
    initial begin
        #20000;
        failures++;
        close_out();
    end
endmodule
